// ### uvfr_pkg.sv
// Package with constants for the undervoltage and turn-on time-out fault response block.
// Function
// - Undervoltage fault sets catch-all status, status-word output bit and undervoltage status bit.
// - A recorded undervoltage fault drives alert active unless that alert is masked.
// - Detection masked until time-out reached, delay done, ramp done, threshold crossed, no overcurrent.
// - Detection is masked whenever the channel is inactive.
// - Detection is masked during the turn-on ramp and the turn-off fall.
// - Response 00 keeps output running, still setting status and alert.
// - Response 01 waits the programmed delay, then applies retry if fault persists.
// - Response 10 disables the output at once, then applies the retry policy.
// - Writing response 11 is unsupported and flags a communication/memory/logic fault.
// - Fault bits clear only on clear, off-then-on, restore, soft reset or power cycle; the communication/memory/logic bit only on clear or power cycle.
// - Retry 000 stays off until cleared; 111 retries without limit.
// - Wait between restart attempts comes from the restart interval setting.
// - Delay field counts 10 us steps and applies only to delayed shutdown.
// - Turn-on time-out fault sets catch-all, word, time-out status bits and alert.
// - A time-out limit of zero disables the turn-on time-out fault response.
// - PWM stays in pulse-skipping mode until the turn-on time-out limit is exceeded.
// - Each fault response command carries exactly one data byte.
// - Undervoltage response command code 0x45, read/write byte, default 0xb8.
// - Turn-on time-out response command code 0x63, read/write byte, default 0xb8.
package uvfr_pkg;
  // ==========================================================================
  // Command codes and defaults.
  localparam logic [7:0] CMD_UV_RESP     = 8'h45;
  localparam logic [7:0] CMD_TON_RESP    = 8'h63;
  localparam logic [7:0] RESP_RST        = 8'hb8;
  // ==========================================================================
  // Field positions in a response byte.
  localparam int         RESP_HI         = 7;
  localparam int         RESP_LO         = 6;
  localparam int         RETRY_HI        = 5;
  localparam int         RETRY_LO        = 3;
  localparam int         DLY_HI          = 2;
  localparam int         DLY_LO          = 0;
  localparam logic [1:0] ACT_IGNORE      = 2'h0;
  localparam logic [1:0] ACT_DELAYED     = 2'h1;
  localparam logic [1:0] ACT_IMMEDIATE   = 2'h2;
  localparam logic [1:0] ACT_BAD         = 2'h3;
  localparam logic [2:0] RETRY_NONE      = 3'h0;
  localparam logic [2:0] RETRY_FOREVER   = 3'h7;
  // ==========================================================================
  // Timing.
  localparam int         CLK_MHZ         = 100;
  localparam int         STEP_US         = 10;
  localparam int         STEP_CYC        = STEP_US * CLK_MHZ;
  localparam logic [9:0] STEP_CYC_M1     = 10'(STEP_CYC - 1);
  // ==========================================================================
  // Response state machine.
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DELAY = 2'b01,
    ST_OFF   = 2'b10,
    ST_WAIT  = 2'b11
  } uvfr_state_t;
endpackage : uvfr_pkg

// ### uvfr_top.sv
// Undervoltage and turn-on time-out fault response logic for one channel.
`timescale 1ns/1ps
module uvfr_top (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic [7:0]  rd_code_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic        clear_faults_i,
  input  wire logic        restore_all_i,
  input  wire logic        soft_reset_i,
  input  wire logic        chan_on_i,
  input  wire logic        ton_delay_done_i,
  input  wire logic        ton_rise_done_i,
  input  wire logic        toff_fall_i,
  input  wire logic        uv_cross_i,
  input  wire logic        oc_present_i,
  input  wire logic        uv_fault_i,
  input  wire logic        ton_max_zero_i,
  input  wire logic        ton_max_hit_i,
  input  wire logic        uv_alert_mask_i,
  input  wire logic        ton_alert_mask_i,
  input  wire logic [15:0] restart_interval_setting_i,
  output logic             none_above_o,
  output logic             word_vout_o,
  output logic             uv_fault_o,
  output logic             ton_fault_o,
  output logic             cml_fault_o,
  output logic             alert_n_o,
  output logic             out_en_o,
  output logic             restart_o,
  output logic             pulse_skip_o,
  output logic             uv_detect_en_o
);
  // ==========================================================================
  // Storage.
  logic [7:0]              uv_resp_r;
  logic [7:0]              ton_resp_r;
  logic                    uv_st_r;
  logic                    ton_st_r;
  logic                    cml_r;
  logic                    alert_r;
  logic                    max_seen_r;
  logic                    chan_on_d_r;
  uvfr_pkg::uvfr_state_t   state_r;
  uvfr_pkg::uvfr_state_t   state_nxt;
  logic [9:0]              tick_r;
  logic [2:0]              steps_r;
  logic [15:0]             wait_r;
  logic                    restart_r;

  // ==========================================================================
  // Decode of command writes and clearing events.
  wire wr_uv        = cmd_wr_i && (cmd_code_i == uvfr_pkg::CMD_UV_RESP);
  wire wr_ton       = cmd_wr_i && (cmd_code_i == uvfr_pkg::CMD_TON_RESP);
  wire bad_act      = cmd_data_i[uvfr_pkg::RESP_HI:uvfr_pkg::RESP_LO] == uvfr_pkg::ACT_BAD;
  wire off_on       = chan_on_i && !chan_on_d_r;
  wire clr_evt      = clear_faults_i || restore_all_i || soft_reset_i || off_on;
  wire [1:0] act    = uv_resp_r[uvfr_pkg::RESP_HI:uvfr_pkg::RESP_LO];
  wire [2:0] retry  = uv_resp_r[uvfr_pkg::RETRY_HI:uvfr_pkg::RETRY_LO];
  wire [2:0] dly    = uv_resp_r[uvfr_pkg::DLY_HI:uvfr_pkg::DLY_LO];
  wire [1:0] tact   = ton_resp_r[uvfr_pkg::RESP_HI:uvfr_pkg::RESP_LO];
  // Unmasking: time-out reached, delay and ramp done, not falling, crossed, no overcurrent.
  wire ton_reached  = max_seen_r || ton_max_zero_i;
  wire det_en       = chan_on_i && ton_reached && ton_delay_done_i && ton_rise_done_i
                      && !toff_fall_i && uv_cross_i && !oc_present_i;
  wire uv_evt       = det_en && uv_fault_i;
  wire ton_evt      = chan_on_i && !ton_max_zero_i && ton_max_hit_i && !max_seen_r
                      && !uv_cross_i;
  wire ton_act      = ton_evt && (tact != uvfr_pkg::ACT_IGNORE);
  wire step_end     = tick_r == uvfr_pkg::STEP_CYC_M1;
  wire dly_end      = step_end && (steps_r == dly);
  wire wait_end     = wait_r == 16'h0000;

  // ==========================================================================
  // Response state machine next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      uvfr_pkg::ST_RUN: begin
        if (ton_act) begin
          state_nxt = uvfr_pkg::ST_OFF;
        end else if (uv_evt && act == uvfr_pkg::ACT_IMMEDIATE) begin
          state_nxt = uvfr_pkg::ST_OFF;
        end else if (uv_evt && act == uvfr_pkg::ACT_DELAYED) begin
          state_nxt = uvfr_pkg::ST_DELAY;
        end
      end
      uvfr_pkg::ST_DELAY: begin
        if (!uv_fault_i || !det_en) begin
          state_nxt = uvfr_pkg::ST_RUN;
        end else if (dly_end) begin
          state_nxt = uvfr_pkg::ST_OFF;
        end
      end
      uvfr_pkg::ST_OFF: begin
        if (retry == uvfr_pkg::RETRY_FOREVER) begin
          state_nxt = uvfr_pkg::ST_WAIT;
        end else if (clr_evt) begin
          state_nxt = uvfr_pkg::ST_RUN;
        end
      end
      uvfr_pkg::ST_WAIT: begin
        if (!chan_on_i) begin
          state_nxt = uvfr_pkg::ST_RUN;
        end else if (wait_end) begin
          state_nxt = uvfr_pkg::ST_RUN;
        end
      end
      default: state_nxt = uvfr_pkg::ST_RUN;
    endcase
  end

  // ==========================================================================
  // Command registers, one data byte each, unsupported response refused.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_resp_r  <= uvfr_pkg::RESP_RST;
      ton_resp_r <= uvfr_pkg::RESP_RST;
    end else begin
      if (wr_uv && !bad_act) begin
        uv_resp_r <= cmd_data_i;
      end
      if (wr_ton && !bad_act) begin
        ton_resp_r <= cmd_data_i;
      end
    end
  end

  // Sticky status flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_st_r  <= 1'b0;
      ton_st_r <= 1'b0;
      cml_r    <= 1'b0;
    end else begin
      uv_st_r  <= uv_evt || (uv_st_r && !clr_evt);
      ton_st_r <= ton_evt || (ton_st_r && !clr_evt);
      cml_r    <= ((wr_uv || wr_ton) && bad_act) || (cml_r && !clear_faults_i);
    end
  end

  // Alert latch: set by an unmasked fault, released by any clearing event.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= (uv_evt && !uv_alert_mask_i) || (ton_evt && !ton_alert_mask_i)
                 || (alert_r && !clr_evt);
    end
  end

  // Turn-on time-out tracking and off-to-on edge detection.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      max_seen_r  <= 1'b0;
      chan_on_d_r <= 1'b0;
    end else begin
      chan_on_d_r <= chan_on_i;
      max_seen_r  <= chan_on_i && (max_seen_r || ton_max_hit_i);
    end
  end

  // State register and restart pulse.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r   <= uvfr_pkg::ST_RUN;
      restart_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      restart_r <= (state_r == uvfr_pkg::ST_WAIT) && wait_end && chan_on_i;
    end
  end

  // Delay timer in 10 us steps, reloaded on each entry into the delay state.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_r  <= 10'h000;
      steps_r <= 3'h0;
    end else if (state_r != uvfr_pkg::ST_DELAY) begin
      tick_r  <= 10'h000;
      steps_r <= 3'h0;
    end else if (step_end) begin
      tick_r  <= 10'h000;
      steps_r <= steps_r + 3'h1;
    end else begin
      tick_r  <= tick_r + 10'h001;
    end
  end

  // Retry interval counter, loaded on entry into the wait state.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r <= 16'h0000;
    end else if (state_r != uvfr_pkg::ST_WAIT) begin
      wait_r <= restart_interval_setting_i;
    end else if (!wait_end) begin
      wait_r <= wait_r - 16'h0001;
    end
  end

  // ==========================================================================
  // Outputs.
  assign none_above_o   = uv_st_r || ton_st_r;
  assign word_vout_o    = uv_st_r || ton_st_r;
  assign uv_fault_o     = uv_st_r;
  assign ton_fault_o    = ton_st_r;
  assign cml_fault_o    = cml_r;
  assign alert_n_o      = !alert_r;
  assign out_en_o       = (state_r == uvfr_pkg::ST_RUN) || (state_r == uvfr_pkg::ST_DELAY);
  assign restart_o      = restart_r;
  assign pulse_skip_o   = chan_on_i && !max_seen_r;
  assign uv_detect_en_o = det_en;
  assign rd_data_o      = (rd_code_i == uvfr_pkg::CMD_UV_RESP)  ? uv_resp_r :
                          (rd_code_i == uvfr_pkg::CMD_TON_RESP) ? ton_resp_r : 8'h00;

  // ==========================================================================
  // Checks.
  sequence s_uv_fault;
    uv_fault_i && det_en;
  endsequence

  property p_uv_status;
    @(posedge ref_clk_i) disable iff (!arst_n_i) s_uv_fault |=> uv_fault_o && none_above_o;
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("uv status not set");

  property p_uv_alert;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      s_uv_fault and (!uv_alert_mask_i) |=> !alert_n_o;
  endproperty
  a_uv_alert: assert property (p_uv_alert) else $error("alert not raised");

  property p_mask_off;
    @(posedge ref_clk_i) disable iff (!arst_n_i) !chan_on_i || toff_fall_i |-> !uv_detect_en_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("detection not masked");

  property p_mask_oc;
    @(posedge ref_clk_i) disable iff (!arst_n_i) oc_present_i || !uv_cross_i |-> !uv_detect_en_o;
  endproperty
  a_mask_oc: assert property (p_mask_oc) else $error("detection not masked");

  property p_ignore;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (state_r == uvfr_pkg::ST_RUN && act == uvfr_pkg::ACT_IGNORE && !ton_act) and s_uv_fault
      |=> out_en_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore response shut down");

  property p_immediate;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (state_r == uvfr_pkg::ST_RUN && act == uvfr_pkg::ACT_IMMEDIATE) and s_uv_fault
      |=> !out_en_o;
  endproperty
  a_immediate: assert property (p_immediate) else $error("output not disabled");

  property p_cml;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_uv && bad_act |=> cml_fault_o && $stable(uv_resp_r);
  endproperty
  a_cml: assert property (p_cml) else $error("bad write not flagged");

  property p_sticky;
    @(posedge ref_clk_i) disable iff (!arst_n_i) uv_fault_o && !clr_evt |=> uv_fault_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit lost");

  property p_skip;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      pulse_skip_o && !ton_max_hit_i |=> pulse_skip_o || !chan_on_i;
  endproperty
  a_skip: assert property (p_skip) else $error("pulse skip dropped");
endmodule : uvfr_top

// ### uvfr_seq_model.sv
// Behavioural model of the channel sequencer that feeds the fault response block.
`timescale 1ns/1ps
module uvfr_seq_model (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic chan_on_i,
  input  wire logic stall_i,
  output logic      ton_delay_done_o,
  output logic      ton_rise_done_o,
  output logic      uv_cross_o,
  output logic      ton_max_hit_o
);
  logic [5:0] cnt_r;
  // ==========================================================================
  // Start-up progress counter, restarted whenever the channel is off.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_r <= 6'h00;
    else if (!chan_on_i) cnt_r <= 6'h00;
    else if (cnt_r != 6'h3f) cnt_r <= cnt_r + 6'h01;
  end
  // Sequence milestones; a stalled ramp never crosses the undervoltage threshold, as a slow output would.
  assign ton_delay_done_o = cnt_r > 6'h04;
  assign ton_rise_done_o  = cnt_r > 6'h0c;
  assign uv_cross_o       = !stall_i && cnt_r > 6'h0a;
  assign ton_max_hit_o    = cnt_r > 6'h10;
endmodule : uvfr_seq_model

// ### undervoltage_fault_response_bench.sv
// Self-checking bench for the undervoltage fault response block.
`timescale 1ns/1ps
module undervoltage_fault_response_bench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, clr = 1'b0, rsa = 1'b0, srst = 1'b0;
  logic on = 1'b0, oc = 1'b0, uvf = 1'b0, tz = 1'b0, um = 1'b0, stall = 1'b0, toff = 1'b0;
  logic [7:0]  code = 8'h00, data = 8'h00, rdc = 8'h00, rd;
  logic [15:0] ivl = 16'h0014;
  logic        na, wv, uvo, tno, cml, aln, oen, rso, psk, den, dd, rdn, cr, hit;
  int          failures = 0, total_checks = 0, seed = 30554, n, k, c;
  int          mreg [2] = '{8'hb8, 8'hb8};
  // ==========================================================================
  // Clock generation.
  always #5 clk = ~clk;
  uvfr_top uvfr_top_i (.ref_clk_i(clk), .arst_n_i(rst_n), .cmd_wr_i(wr), .cmd_code_i(code),
    .cmd_data_i(data), .rd_code_i(rdc), .rd_data_o(rd), .clear_faults_i(clr),
    .restore_all_i(rsa), .soft_reset_i(srst), .chan_on_i(on), .ton_delay_done_i(dd),
    .ton_rise_done_i(rdn), .toff_fall_i(toff), .uv_cross_i(cr), .oc_present_i(oc),
    .uv_fault_i(uvf), .ton_max_zero_i(tz), .ton_max_hit_i(hit), .uv_alert_mask_i(um),
    .ton_alert_mask_i(um), .restart_interval_setting_i(ivl), .none_above_o(na),
    .word_vout_o(wv), .uv_fault_o(uvo), .ton_fault_o(tno), .cml_fault_o(cml),
    .alert_n_o(aln), .out_en_o(oen), .restart_o(rso), .pulse_skip_o(psk),
    .uv_detect_en_o(den));
  uvfr_seq_model uvfr_seq_model_i (.ref_clk_i(clk), .arst_n_i(rst_n), .chan_on_i(on),
    .stall_i(stall), .ton_delay_done_o(dd), .ton_rise_done_o(rdn), .uv_cross_o(cr),
    .ton_max_hit_o(hit));
  // ==========================================================================
  // Comparison, verdict and bus tasks.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic cyc(input int m);
    repeat (m) @(negedge clk);
  endtask : cyc
  // Reads back one response byte and compares it with the model.
  task automatic rd_chk(input logic [7:0] cc);
    rdc = cc;
    #1;
    chk(rd, (cc == 8'h45) ? mreg[0][7:0] : (cc == 8'h63) ? mreg[1][7:0] : 8'h00);
  endtask : rd_chk
  // Writes one data byte to one command; unsupported responses leave the model alone.
  task automatic wr_cmd(input logic [7:0] cc, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    code = cc;
    data = d;
    @(negedge clk);
    wr = 1'b0;
    if (d[7:6] != 2'h3) mreg[cc == 8'h63] = d;
    rd_chk(cc);
  endtask : wr_cmd
  task automatic power();
    @(negedge clk);
    on = 1'b0;
    cyc(2);
    on = 1'b1;
    cyc(30);
  endtask : power
  task automatic fault();
    @(negedge clk);
    uvf = 1'b1;
    @(negedge clk);
    uvf = 1'b0;
    @(negedge clk);
  endtask : fault
  task automatic kick(input int kind);
    @(negedge clk);
    clr = (kind == 0);
    rsa = (kind == 1);
    srst = (kind == 2);
    @(negedge clk);
    {clr, rsa, srst} = 3'b000;
    @(negedge clk);
  endtask : kick
  // ==========================================================================
  // Watchdog against a hang.
  initial begin
    #600000;
    failures++;
    final_report();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    cyc(4);
    rst_n = 1'b1;
    rd_chk(8'h45);
    rd_chk(8'h63);
    rd_chk(8'h47);
    chk({uvo, tno, na, aln}, 8'h01);
    cyc(3);
    chk(den, 1'b0);
    on = 1'b1;
    cyc(9);
    chk({den, psk}, 8'h01);
    cyc(25);
    chk({den, psk}, 8'h02);
    chk(tno, 1'b0);
    oc = 1'b1;
    toff = 1'b1;
    #1;
    chk(den, 1'b0);
    oc = 1'b0;
    #1;
    chk(den, 1'b0);
    toff = 1'b0;
    wr_cmd(8'h45, 8'hc0);
    chk(cml, 1'b1);
    kick(0);
    chk(cml, 1'b0);
    wr_cmd(8'h45, 8'h80);
    for (k = 0; k < 3; k++) begin
      power();
      fault();
      chk({na, wv, uvo, aln, oen}, 8'h1c);
      cyc(50);
      chk({uvo, oen}, 8'h02);
      kick(k);
      chk({uvo, na, aln}, 8'h01);
    end
    wr_cmd(8'h45, 8'h00);
    um = 1'b1;
    fault();
    chk({uvo, aln, oen}, 8'h07);
    um = 1'b0;
    kick(0);
    n = $random(seed) & 7;
    wr_cmd(8'h45, 8'h40 | n[7:0]);
    @(negedge clk);
    uvf = 1'b1;
    cyc((n + 1) * 1000 - 4);
    chk(oen, 1'b1);
    cyc(8);
    chk({oen, uvo}, 8'h01);
    uvf = 1'b0;
    kick(0);
    wr_cmd(8'h45, 8'h40);
    uvf = 1'b1;
    cyc(500);
    uvf = 1'b0;
    cyc(1000);
    chk(oen, 1'b1);
    kick(0);
    ivl = 16'(10 + ($random(seed) & 31));
    wr_cmd(8'h45, 8'hb8);
    fault();
    chk(oen, 1'b0);
    c = 0;
    while (rso !== 1'b1 && c < 200) begin
      @(negedge clk);
      c++;
    end
    chk(c >= ivl && c <= ivl + 8, 1'b1);
    cyc(2);
    chk(oen, 1'b1);
    kick(0);
    stall = 1'b1;
    tz = 1'b1;
    power();
    chk(tno, 1'b0);
    tz = 1'b0;
    power();
    chk({tno, na, wv}, 8'h07);
    chk(aln, 1'b0);
    final_report();
  end
endmodule : undervoltage_fault_response_bench
